// ---- src/tws_cond.sv ----
`timescale 1ns/1ns
module tws_cond
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Synchronised bus levels
  input  wire tws_line_type  line_in,
  // Detected bus events
  output tws_event_type      ev
);
  tws_line_type prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= line_in;
    end
  end

  // SDA moving while SCL stays high marks START or STOP
  always_comb begin
    ev.scl_rise = !prev_reg.scl && line_in.scl;
    ev.scl_fall = prev_reg.scl && !line_in.scl;
    ev.start    = prev_reg.scl && line_in.scl && prev_reg.sda && !line_in.sda;
    ev.stop     = prev_reg.scl && line_in.scl && !prev_reg.sda && line_in.sda;
  end
endmodule

// ---- src/tws_pkg.sv ----
package tws_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_OWN   = 8'h00;
  localparam logic [7:0] OFS_CTRL  = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_DATA  = 8'h0c;
  localparam logic [7:0] OFS_SLEEP = 8'h10;
  // Control register bit positions
  localparam int CB_FLAG = 7;
  localparam int CB_ACK  = 6;
  localparam int CB_STA  = 5;
  localparam int CB_STO  = 4;
  localparam int CB_WCOL = 3;
  localparam int CB_EN   = 2;
  localparam int CB_IE   = 0;
  // Sleep register bit positions
  localparam int SB_SLEEP = 0;
  localparam int SB_WAKE  = 1;
  // Reset values
  localparam logic [7:0] OWN_RST   = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'hff;
  localparam logic [1:0] PRESC_RST = 2'h0;
  // Status codes and general-call address
  localparam logic [7:0] ST_START     = 8'h08;
  localparam logic [7:0] ST_SW_OWN    = 8'h60;
  localparam logic [7:0] ST_SW_ARB    = 8'h68;
  localparam logic [7:0] ST_GC        = 8'h70;
  localparam logic [7:0] ST_GC_ARB    = 8'h78;
  localparam logic [7:0] ST_RX_ACK    = 8'h80;
  localparam logic [7:0] ST_RX_NACK   = 8'h88;
  localparam logic [7:0] ST_GC_ACK    = 8'h90;
  localparam logic [7:0] ST_GC_NACK   = 8'h98;
  localparam logic [7:0] ST_STOP      = 8'ha0;
  localparam logic [7:0] ST_SR_OWN    = 8'ha8;
  localparam logic [7:0] ST_SR_ARB    = 8'hb0;
  localparam logic [7:0] ST_TX_ACK    = 8'hb8;
  localparam logic [7:0] ST_TX_NACK   = 8'hc0;
  localparam logic [7:0] ST_TX_LAST   = 8'hc8;
  localparam logic [7:0] ST_NONE      = 8'hf8;
  localparam logic [6:0] GC_ADDR      = 7'h00;
  // Timing
  localparam int CLK_NS         = 100;
  localparam int BUS_FREE_NS    = 4700;
  localparam int START_HOLD_NS  = 4000;
  localparam int BUS_FREE_CYC   = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic scl;
    logic sda;
  } tws_line_type;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } tws_event_type;

  typedef enum {
    S_IDLE, S_ADDR, S_AACK, S_RX, S_RXACK, S_TX, S_TXACK,
    S_WAIT, S_GSDA, S_GHOLD, S_GEND
  } tws_state_type;
endpackage

// ---- src/tws_sync.sv ----
`timescale 1ns/1ns
module tws_sync
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Pin levels in and synchronised levels out
  input  wire tws_line_type pin_in,
  output tws_line_type      line_out
);
  tws_line_type meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '1;
      line_out <= '1;
    end else begin
      meta_reg <= pin_in;
      line_out <= meta_reg;
    end
  end
endmodule

// ---- src/tws_top.sv ----
// Operation
// - General-call byte acked reports 0x90; ack_enable then picks next ack.
// - General-call byte not acked reports 0x98; clear returns to not addressed.
// - STOP or repeated START while addressed reports 0xA0, data kept.
// - Not addressed: ack_enable 0 ignores all, 1 matches own and enabled call.
// - start_request set at clear issues START once the bus is free.
// - Upper seven bits match own address; bit 0 enables general call.
// - Read bit enters transmit mode, write bit enters receive mode.
// - After own address and direction, flag set with valid status.
// - Addressed for read after lost arbitration reports 0xB0.
// - ack_enable cleared in transmit sends last byte, then 0xC0 or 0xC8.
// - After last byte, further master clocks are ignored; SDA released.
// - Master ack after declared last byte reports 0xC8.
// - ack_enable zero ignores own address; setting it resumes matching at once.
// - In sleep, address match is still acked and wakes the part.
// - After wake, SCL held low until completion_flag cleared by one.
// - Data register need not hold last bus byte after wake.
// - Own read address acked reports 0xA8; cleared flag sends loaded byte.
// - Transmitted byte acked by master reports 0xB8 and waits for software.
// - ack_enable cleared in receive returns not-ack after next byte.
// - Status reads 0xF8 while completion_flag is clear.
`timescale 1ns/1ns
module tws_top
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Wake request to the power controller
  output logic             wake_o
);
  tws_line_type  pin_in;
  tws_line_type  ln;
  tws_event_type ev;
  tws_state_type state_reg;

  logic [7:0] own_slave_address;
  logic       completion_flag;
  logic       ack_enable;
  logic       start_request;
  logic       stop_request;
  logic       write_collision_flag;
  logic       interface_enable;
  logic       irq_enable;
  logic [7:0] status_code_reg;
  logic [1:0] presc_reg;
  logic [7:0] byte_data_reg;
  logic       sleep_reg;
  logic       wake_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic [5:0] tmr_reg;
  logic [5:0] free_reg;
  logic       gc_reg;
  logic       rd_reg;
  logic       last_reg;
  logic       mack_reg;
  logic       arb_lost_reg;
  logic       busy_reg;
  logic       set_req_reg;
  logic       rx_load_reg;
  logic       wr;
  logic       flag_clr;
  logic       addressed;
  logic       bus_free;
  logic       woke;

  function automatic logic is_tx_code(input logic [7:0] c);
    return c == ST_SR_OWN || c == ST_SR_ARB || c == ST_TX_ACK;
  endfunction

  function automatic logic is_rx_code(input logic [7:0] c);
    return c == ST_SW_OWN || c == ST_SW_ARB || c == ST_GC || c == ST_GC_ARB ||
           c == ST_RX_ACK || c == ST_GC_ACK;
  endfunction

  function automatic logic wr_to(input logic [7:0] ofs);
    return wr && paddr == ofs;
  endfunction

  assign pin_in.scl = scl_i;
  assign pin_in.sda = sda_i;

  tws_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (pin_in),
    .line_out (ln)
  );

  tws_cond u_cond (
    .pclk    (pclk),
    .presetn (presetn),
    .line_in (ln),
    .ev      (ev)
  );

  assign wr        = psel && penable && pwrite && pready;
  assign flag_clr  = wr_to(OFS_CTRL) && pwdata[CB_FLAG] && completion_flag;
  assign addressed = state_reg inside {S_RX, S_RXACK, S_TX, S_TXACK};
  assign bus_free  = !busy_reg && free_reg == 6'(BUS_FREE_CYC);
  assign woke      = state_reg == S_AACK && ev.scl_fall && sleep_reg;

  // APB answer prepared in the setup cycle, so the access never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        case (paddr)
          OFS_OWN: prdata[7:0] <= own_slave_address;
          OFS_CTRL: prdata[7:0] <= {completion_flag, ack_enable, start_request,
                                    stop_request, write_collision_flag,
                                    interface_enable, 1'b0, irq_enable};
          OFS_STAT: prdata[7:0] <= completion_flag ?
                                   {status_code_reg[7:3], 1'b0, presc_reg} :
                                   {ST_NONE[7:3], 1'b0, presc_reg};
          OFS_DATA: prdata[7:0] <= byte_data_reg;
          OFS_SLEEP: prdata[7:0] <= {6'h0, wake_reg, sleep_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Own address and control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_slave_address <= OWN_RST;
      ack_enable        <= 1'b0;
      start_request     <= 1'b0;
      stop_request      <= 1'b0;
      interface_enable  <= 1'b0;
      irq_enable        <= 1'b0;
      presc_reg         <= PRESC_RST;
    end else begin
      if (wr_to(OFS_OWN)) begin
        own_slave_address <= pwdata[7:0];
      end
      if (wr_to(OFS_CTRL)) begin
        ack_enable       <= pwdata[CB_ACK];
        start_request    <= pwdata[CB_STA];
        stop_request     <= pwdata[CB_STO];
        interface_enable <= pwdata[CB_EN];
        irq_enable       <= pwdata[CB_IE];
      end else if (state_reg == S_IDLE) begin
        stop_request <= 1'b0;
      end
      if (wr_to(OFS_STAT)) begin
        presc_reg <= pwdata[1:0];
      end
    end
  end

  // Flag: a hardware set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_flag <= 1'b0;
    end else if (set_req_reg) begin
      completion_flag <= 1'b1;
    end else if (flag_clr) begin
      completion_flag <= 1'b0;
    end
  end

  // Data register and write collision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_data_reg        <= DATA_RST;
      write_collision_flag <= 1'b0;
    end else begin
      if (rx_load_reg && !wake_reg) begin
        byte_data_reg <= shift_reg;
      end else if (wr_to(OFS_DATA) && completion_flag) begin
        byte_data_reg <= pwdata[7:0];
      end
      if (wr_to(OFS_DATA) && !completion_flag) begin
        write_collision_flag <= 1'b1;
      end else if (wr_to(OFS_DATA)) begin
        write_collision_flag <= 1'b0;
      end
    end
  end

  // Sleep entry by software, wake on address match in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
      wake_reg  <= 1'b0;
    end else begin
      if (woke) begin
        sleep_reg <= 1'b0;
        wake_reg  <= 1'b1;
      end else if (wr_to(OFS_SLEEP)) begin
        sleep_reg <= pwdata[SB_SLEEP];
      end
      if (flag_clr && !woke) begin
        wake_reg <= 1'b0;
      end
    end
  end

  // Bus busy tracking, free time and arbitration loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg     <= 1'b0;
      free_reg     <= 6'h0;
      arb_lost_reg <= 1'b0;
    end else begin
      if (ev.start) begin
        busy_reg <= 1'b1;
      end else if (ev.stop) begin
        busy_reg <= 1'b0;
      end
      if (busy_reg || ev.start) begin
        free_reg <= 6'h0;
      end else if (free_reg != 6'(BUS_FREE_CYC)) begin
        free_reg <= free_reg + 6'h1;
      end
      if (ev.start && start_request && state_reg == S_IDLE) begin
        arb_lost_reg <= 1'b1;
      end else if (flag_clr) begin
        arb_lost_reg <= 1'b0;
      end
    end
  end

  // Line drivers only ever pull low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign wake_o = wake_reg;

  // Slave protocol engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= S_IDLE;
      status_code_reg <= ST_NONE;
      shift_reg       <= 8'h00;
      cnt_reg         <= 4'h0;
      tmr_reg         <= 6'h0;
      gc_reg          <= 1'b0;
      rd_reg          <= 1'b0;
      last_reg        <= 1'b0;
      mack_reg        <= 1'b0;
      sda_oe          <= 1'b0;
      scl_oe          <= 1'b0;
      set_req_reg     <= 1'b0;
      rx_load_reg     <= 1'b0;
    end else begin
      set_req_reg <= 1'b0;
      rx_load_reg <= 1'b0;
      if (!interface_enable) begin
        state_reg <= S_IDLE;
        sda_oe    <= 1'b0;
        scl_oe    <= 1'b0;
      end else if ((ev.stop || ev.start) && addressed) begin
        status_code_reg <= ST_STOP;
        set_req_reg     <= 1'b1;
        sda_oe          <= 1'b0;
        state_reg       <= S_WAIT;
      end else if (ev.start && state_reg inside {S_IDLE, S_ADDR}) begin
        state_reg <= S_ADDR;
        cnt_reg   <= 4'h0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (start_request && bus_free) begin
              sda_oe    <= 1'b1;
              tmr_reg   <= 6'h0;
              state_reg <= S_GSDA;
            end
          end
          S_ADDR: begin
            if (ev.scl_rise) begin
              shift_reg <= {shift_reg[6:0], ln.sda};
              cnt_reg   <= cnt_reg + 4'h1;
            end else if (ev.scl_fall && cnt_reg == 4'h8) begin
              if (ack_enable && shift_reg[7:1] == own_slave_address[7:1]) begin
                sda_oe    <= 1'b1;
                gc_reg    <= 1'b0;
                rd_reg    <= shift_reg[0];
                state_reg <= S_AACK;
              end else if (ack_enable && own_slave_address[0] &&
                           shift_reg == {GC_ADDR, 1'b0}) begin
                sda_oe    <= 1'b1;
                gc_reg    <= 1'b1;
                rd_reg    <= 1'b0;
                state_reg <= S_AACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (ev.scl_fall) begin
              sda_oe      <= 1'b0;
              scl_oe      <= 1'b1;
              set_req_reg <= 1'b1;
              state_reg   <= S_WAIT;
              if (rd_reg) begin
                status_code_reg <= arb_lost_reg ? ST_SR_ARB : ST_SR_OWN;
              end else if (gc_reg) begin
                status_code_reg <= arb_lost_reg ? ST_GC_ARB : ST_GC;
              end else begin
                status_code_reg <= arb_lost_reg ? ST_SW_ARB : ST_SW_OWN;
              end
            end
          end
          S_RX: begin
            if (ev.scl_rise) begin
              shift_reg <= {shift_reg[6:0], ln.sda};
              cnt_reg   <= cnt_reg + 4'h1;
            end else if (ev.scl_fall && cnt_reg == 4'h8) begin
              sda_oe    <= ack_enable;
              mack_reg  <= ack_enable;
              state_reg <= S_RXACK;
            end
          end
          S_RXACK: begin
            if (ev.scl_fall) begin
              sda_oe      <= 1'b0;
              scl_oe      <= 1'b1;
              set_req_reg <= 1'b1;
              rx_load_reg <= 1'b1;
              state_reg   <= S_WAIT;
              if (gc_reg) begin
                status_code_reg <= mack_reg ? ST_GC_ACK : ST_GC_NACK;
              end else begin
                status_code_reg <= mack_reg ? ST_RX_ACK : ST_RX_NACK;
              end
            end
          end
          S_TX: begin
            if (ev.scl_fall) begin
              if (cnt_reg == 4'h7) begin
                sda_oe    <= 1'b0;
                state_reg <= S_TXACK;
              end else begin
                sda_oe    <= !shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b1};
                cnt_reg   <= cnt_reg + 4'h1;
              end
            end
          end
          S_TXACK: begin
            if (ev.scl_rise) begin
              mack_reg <= !ln.sda;
            end else if (ev.scl_fall) begin
              scl_oe      <= 1'b1;
              set_req_reg <= 1'b1;
              state_reg   <= S_WAIT;
              if (!mack_reg) begin
                status_code_reg <= ST_TX_NACK;
              end else if (last_reg || !ack_enable) begin
                status_code_reg <= ST_TX_LAST;
              end else begin
                status_code_reg <= ST_TX_ACK;
              end
            end
          end
          S_WAIT: begin
            if (flag_clr) begin
              scl_oe  <= 1'b0;
              cnt_reg <= 4'h0;
              if (is_tx_code(status_code_reg)) begin
                shift_reg <= byte_data_reg;
                sda_oe    <= !byte_data_reg[7];
                last_reg  <= !pwdata[CB_ACK];
                state_reg <= S_TX;
              end else if (is_rx_code(status_code_reg)) begin
                state_reg <= S_RX;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_GSDA: begin
            tmr_reg <= tmr_reg + 6'h1;
            if (tmr_reg == 6'(START_HOLD_CYC)) begin
              scl_oe          <= 1'b1;
              status_code_reg <= ST_START;
              set_req_reg     <= 1'b1;
              state_reg       <= S_GHOLD;
            end
          end
          S_GHOLD: begin
            if (flag_clr) begin
              scl_oe    <= 1'b0;
              tmr_reg   <= 6'h0;
              state_reg <= S_GEND;
            end
          end
          S_GEND: begin
            tmr_reg <= tmr_reg + 6'h1;
            if (tmr_reg == 6'(START_HOLD_CYC)) begin
              sda_oe    <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ---- tb/two_wire_slave_tx_and_gcall_rx_bench.sv ----
`timescale 1ns/1ns
module two_wire_slave_tx_and_gcall_rx_bench
  import tws_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, v, b;
  logic [31:0] pwdata, prdata;
  logic        scl_o, scl_oe, sda_o, sda_oe, wake_o, m_scl, m_sda, a, e;
  int          fails, tests_run;
  wire         scl = !(scl_oe || m_scl);
  wire         sda = !(sda_oe || m_sda);
  tws_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .wake_o(wake_o)
  );
  tws_master m (.pclk(pclk), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
  task automatic close_out;
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    v = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] x, input string n);
    apb(1'b0, ad, 8'h00);
    chk(n, x, v);
  endtask
  task automatic st(input logic [7:0] x);
    do apb(1'b0, OFS_CTRL, 8'h00);
    while (v[CB_FLAG] !== 1'b1);
    apb(1'b0, OFS_STAT, 8'h00);
    chk("status", x, v & 8'hf8);
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fails, tests_run} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_STAT, ST_NONE, "stat_rst");
    rd(OFS_DATA, DATA_RST, "data_rst");
    rd(OFS_OWN, OWN_RST, "own_rst");
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped", 8'h01, {7'h0, e});
    apb(1'b1, OFS_OWN, 8'h55);
    apb(1'b1, OFS_CTRL, 8'h04);
    m.start();
    m.wb(8'h55, a);
    chk("ack_off", 8'h00, {7'h0, a});
    m.stop();
    rd(OFS_STAT, ST_NONE, "stat_idle");
    apb(1'b1, OFS_CTRL, 8'h44);
    m.start();
    m.wb(8'h55, a);
    chk("ack_on", 8'h01, {7'h0, a});
    st(ST_SR_OWN);
    apb(1'b1, OFS_DATA, 8'ha5);
    apb(1'b1, OFS_CTRL, 8'hc4);
    m.rb(b, 1'b1);
    chk("tx0", 8'ha5, b);
    st(ST_TX_ACK);
    apb(1'b1, OFS_DATA, 8'h3c);
    apb(1'b1, OFS_CTRL, 8'h84);
    m.rb(b, 1'b1);
    chk("tx1", 8'h3c, b);
    st(ST_TX_LAST);
    apb(1'b1, OFS_CTRL, 8'hc4);
    m.rb(b, 1'b1);
    chk("tx_ones", 8'hff, b);
    m.stop();
    rd(OFS_STAT, ST_NONE, "stat_done");
    m.start();
    m.wb(8'h55, a);
    st(ST_SR_OWN);
    apb(1'b1, OFS_DATA, 8'h81);
    apb(1'b1, OFS_CTRL, 8'hc4);
    m.rb(b, 1'b0);
    chk("tx2", 8'h81, b);
    st(ST_TX_NACK);
    apb(1'b1, OFS_CTRL, 8'hc4);
    m.stop();
    m.start();
    m.wb(8'h00, a);
    chk("gc_ack", 8'h01, {7'h0, a});
    st(ST_GC);
    apb(1'b1, OFS_CTRL, 8'hc4);
    m.wb(8'h11, a);
    chk("gc_d0", 8'h01, {7'h0, a});
    st(ST_GC_ACK);
    rd(OFS_DATA, 8'h11, "gc_data");
    apb(1'b1, OFS_CTRL, 8'h84);
    m.wb(8'h22, a);
    chk("gc_d1", 8'h00, {7'h0, a});
    st(ST_GC_NACK);
    apb(1'b1, OFS_CTRL, 8'hc4);
    m.stop();
    rd(OFS_STAT, ST_NONE, "gc_end");
    m.start();
    m.wb(8'h54, a);
    st(ST_SW_OWN);
    apb(1'b1, OFS_CTRL, 8'hc4);
    m.wb(8'h5a, a);
    st(ST_RX_ACK);
    apb(1'b1, OFS_CTRL, 8'hc4);
    m.stop();
    st(ST_STOP);
    rd(OFS_DATA, 8'h5a, "stop_data");
    apb(1'b1, OFS_CTRL, 8'hc4);
    apb(1'b1, OFS_OWN, 8'h54);
    m.start();
    m.wb(8'h00, a);
    chk("gc_off", 8'h00, {7'h0, a});
    m.stop();
    apb(1'b1, OFS_SLEEP, 8'h01);
    m.start();
    m.wb(8'h54, a);
    st(ST_SW_OWN);
    rd(OFS_SLEEP, 8'h02, "wake_reg");
    chk("wake_pin", 8'h01, {7'h0, wake_o});
    chk("wake_hold", 8'h01, {7'h0, scl_oe});
    apb(1'b1, OFS_CTRL, 8'hc4);
    rd(OFS_SLEEP, 8'h00, "wake_clr");
    m.stop();
    st(ST_STOP);
    apb(1'b1, OFS_CTRL, 8'he4);
    m.start();
    m.wb(8'h55, a);
    st(ST_SR_ARB);
    apb(1'b1, OFS_DATA, 8'h96);
    apb(1'b1, OFS_CTRL, 8'ha4);
    m.rb(b, 1'b0);
    chk("tx_arb", 8'h96, b);
    st(ST_TX_NACK);
    apb(1'b1, OFS_CTRL, 8'he4);
    m.stop();
    st(ST_START);
    apb(1'b1, OFS_CTRL, 8'hc4);
    close_out();
  end
endmodule

// ---- tb/tws_master.sv ----
`timescale 1ns/1ns
module tws_master (
  // Clock and bus levels
  input  wire logic pclk,
  input  wire logic scl,
  input  wire logic sda,
  // Open-drain pulls
  output logic      scl_low,
  output logic      sda_low
);
  initial {scl_low, sda_low} = 2'b00;
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Release SCL and wait out slave stretching
  task automatic hi;
    scl_low <= 1'b0;
    do tk(1);
    while (scl !== 1'b1);
  endtask
  // One bit: low 5 cycles, high 3; data sampled while high
  task automatic bit_io(input logic b, output logic r);
    tk(2);
    sda_low <= !b;
    tk(3);
    hi();
    tk(1);
    r = sda;
    tk(1);
    scl_low <= 1'b1;
  endtask
  task automatic start;
    sda_low <= 1'b1;
    tk(5);
    scl_low <= 1'b1;
  endtask
  task automatic stop;
    tk(2);
    sda_low <= 1'b1;
    tk(3);
    hi();
    tk(4);
    sda_low <= 1'b0;
    tk(8);
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rb(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// ---- tb/tws_top_asserts.sv ----
`timescale 1ns/1ns
module tws_top_asserts
  import tws_pkg::*;
(
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Bus pins and wake
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        wake_o
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire clr = psel && penable && pready && pwrite && paddr == OFS_CTRL && pwdata[CB_FLAG];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    s_setup ##1 (psel && penable);
  endsequence
  property p_od;
    !scl_o && !sda_o;
  endproperty
  property p_rdy;
    s_setup |=> pready;
  endproperty
  property p_one;
    s_acc |=> !pready;
  endproperty
  property p_idle;
    !psel |-> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_unm;
    psel && !penable && !pwrite && paddr > OFS_SLEEP |=> pslverr && prdata == 32'h0;
  endproperty
  property p_up;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  property p_hold;
    scl_oe && !clr |=> scl_oe;
  endproperty
  property p_rel;
    scl_oe && clr |=> !scl_oe;
  endproperty
  a_od: assert property (p_od) else $error("bus pin driven high");
  a_rdy: assert property (p_rdy) else $error("pready missing after setup");
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  a_idle: assert property (p_idle) else $error("pready without psel");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_unm: assert property (p_unm) else $error("unmapped read not refused");
  a_up: assert property (p_up) else $error("upper read bits not zero");
  a_hold: assert property (p_hold) else $error("scl released before clear");
  a_rel: assert property (p_rel) else $error("scl not released on clear");
endmodule

bind tws_top tws_top_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .wake_o(wake_o)
);
